/* File: src/isl_sleep_target.v */
// Target-side sleep entry with acknowledge release on the ninth clock
// How it works
// R1: The target acknowledges the last reserved target identifier byte of the sleep sequence.
// R2: After that acknowledge the target lets go of the data line after the ninth rising clock.
// R3: Sleep entry begins at that ninth rising edge without waiting for a STOP.
// R4: A release while the clock is high makes a spurious STOP, and this is kept as is.
// R5: The master may ignore the spurious STOP that follows the final acknowledge.
// R6: Or the master samples the acknowledge and drives the data line low itself.
// R7: The spurious STOP behaviour belongs to revision A silicon and is not corrected.
// R8: After wake-up the target is ready again within the sleep recovery time.
// R9: While asleep the target ignores traffic other than its wake-up access and never drives data.
`timescale 1ns/100ps
`include "isl_map.vh"
module isl_sleep_target
#(
  // Cycles of recovery after wake-up, shortened in simulation
  parameter REC_CYCLES = `ISL_TREC_US * `ISL_CLK_MHZ,
  // Seven-bit address answered as wake-up while asleep
  parameter [6:0] WAKE_ADDR = 7'h50
)
(
  // Clock and reset
  input wire i_clk_sys,
  input wire i_rst_n,
  // Bus pins
  input wire i_scl,
  input wire i_sda,
  output wire o_sda,
  output wire o_sda_oe,
  // Sleep control and status
  input wire i_sleep_armed,
  output reg o_asleep,
  output reg o_ready,
  output reg o_stop_seen
);
  reg rst_m_r;
  reg rst_r;
  wire [1:0] pins_s;
  reg scl_d_r;
  reg sda_d_r;
  reg [1:0] state_r;
  reg [3:0] bit_cnt_r;
  reg [7:0] shift_r;
  reg drive_r;
  reg sleep_byte_r;
  reg waking_r;
  reg [31:0] rec_cnt_r;
  wire scl;
  wire sda;
  wire scl_rise;
  wire scl_fall;
  wire start_c;
  wire stop_c;
  wire [7:0] byte_nxt;
  wire sleep_go_c;

  // ==========================================================
  // Reset release through two flops
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_m_r <= 1'b0;
      rst_r <= 1'b0;
    end
    else
    begin
      rst_m_r <= 1'b1;
      rst_r <= rst_m_r;
    end
  end

  // Pin synchroniser, bus clock is sampled like any other pin
  isl_sync #(.WIDTH(2)) u_sync
  (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(rst_r),
    .i_async({i_scl, i_sda}),
    .o_sync(pins_s)
  );
  assign scl = pins_s[1];
  assign sda = pins_s[0];

  // ==========================================================
  // Edge and condition detection on synchronised copies
  always @(posedge i_clk_sys or negedge rst_r)
  begin
    if (!rst_r)
    begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      scl_d_r <= scl;
      sda_d_r <= sda;
    end
  end
  assign scl_rise = scl & ~scl_d_r;
  assign scl_fall = ~scl & scl_d_r;
  assign start_c = scl & scl_d_r & sda_d_r & ~sda;
  // A rising data line with clock high; our own release can cause it
  assign stop_c = scl & scl_d_r & ~sda_d_r & sda; // R4
  assign byte_nxt = {shift_r[6:0], sda};
  // Sleep entry strobe, so ready drops in the same cycle as asleep rises
  assign sleep_go_c = (state_r == `ISL_ST_ACK) & scl_rise & sleep_byte_r & ~start_c & ~stop_c;

  // Open drain: only ever pull low
  assign o_sda = 1'b0;
  assign o_sda_oe = drive_r;

  // ==========================================================
  // Byte receiver, acknowledge and sleep entry
  always @(posedge i_clk_sys or negedge rst_r)
  begin
    if (!rst_r)
    begin
      state_r <= `ISL_ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      drive_r <= 1'b0;
      sleep_byte_r <= 1'b0;
      o_asleep <= 1'b0;
      o_stop_seen <= 1'b0;
    end
    else
    begin
      o_stop_seen <= stop_c;
      if (start_c)
      begin
        // Any START resynchronises the byte counter
        state_r <= `ISL_ST_ADDR;
        bit_cnt_r <= 4'h0;
        drive_r <= 1'b0;
      end
      else if (stop_c)
      begin
        state_r <= `ISL_ST_IDLE;
        drive_r <= 1'b0;
      end
      else
      begin
        case (state_r)
          `ISL_ST_IDLE:
          begin
            drive_r <= 1'b0;
          end
          `ISL_ST_ADDR:
          begin
            if (scl_rise)
            begin
              shift_r <= byte_nxt;
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
            if (scl_fall && bit_cnt_r == `ISL_BYTE_BITS)
            begin
              if (!o_asleep && i_sleep_armed && shift_r == `ISL_RSV_TARGET_ID)
              begin
                drive_r <= 1'b1; // R1
                sleep_byte_r <= 1'b1;
                state_r <= `ISL_ST_ACK;
              end
              else if (o_asleep && shift_r[7:1] == WAKE_ADDR)
              begin
                // Wake access is not acknowledged; it only starts recovery
                o_asleep <= 1'b0;
                state_r <= `ISL_ST_SKIP;
              end
              else
              begin
                state_r <= `ISL_ST_SKIP; // R9
              end
            end
          end
          `ISL_ST_ACK:
          begin
            // Release right after ninth rise, clock still high
            if (scl_rise) // R7
            begin
              drive_r <= 1'b0; // R2
              if (sleep_byte_r)
              begin
                o_asleep <= 1'b1; // R3
              end
              sleep_byte_r <= 1'b0;
              state_r <= `ISL_ST_IDLE;
            end
          end
          `ISL_ST_SKIP:
          begin
            drive_r <= 1'b0;
          end
          default:
          begin
            state_r <= `ISL_ST_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Recovery timer after wake-up
  always @(posedge i_clk_sys or negedge rst_r)
  begin
    if (!rst_r)
    begin
      waking_r <= 1'b0;
      rec_cnt_r <= 32'h0000_0000;
      o_ready <= 1'b1;
    end
    else if (o_asleep || sleep_go_c)
    begin
      o_ready <= 1'b0;
      waking_r <= 1'b1;
      rec_cnt_r <= 32'h0000_0000;
    end
    else if (waking_r)
    begin
      // Ready within the recovery bound
      if (rec_cnt_r >= REC_CYCLES - 1)
      begin
        waking_r <= 1'b0;
        o_ready <= 1'b1; // R8
      end
      else
      begin
        rec_cnt_r <= rec_cnt_r + 32'h0000_0001;
      end
    end
  end
endmodule // isl_sleep_target

/* File: src/isl_map.vh */
// Constants for the sleep-entry target block
`ifndef ISL_MAP_VH
`define ISL_MAP_VH
// ==========================================================
// Bus byte and bit counts
`define ISL_RSV_TARGET_ID 8'h86
`define ISL_BYTE_BITS 4'h8
`define ISL_ACK_BIT 4'h9
// ==========================================================
// Sleep recovery time, microseconds and clock rate
`define ISL_TREC_US 400
`define ISL_CLK_MHZ 200
// ==========================================================
// Controller states
`define ISL_ST_IDLE 2'h0
`define ISL_ST_ADDR 2'h1
`define ISL_ST_ACK 2'h2
`define ISL_ST_SKIP 2'h3
`endif

/* File: src/isl_sync.v */
// Two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/100ps
module isl_sync
#(
  parameter WIDTH = 2
)
(
  // Clock and reset
  input wire i_clk_sys,
  input wire i_rst_n,
  // Asynchronous in, synchronous out
  input wire [WIDTH-1:0] i_async,
  output reg [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] meta_r;
  // ==========================================================
  // First stage feeds only the second
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta_r <= {WIDTH{1'b1}};
      o_sync <= {WIDTH{1'b1}};
    end
    else
    begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule // isl_sync

/* File: dv/isl_sleep_target_sva.sv */
// Checker for the sleep-entry target ports
`timescale 1ns/100ps
module isl_sleep_target_sva #(parameter int REC_CYCLES = 50)
(
  // Watched ports
  input wire i_clk_sys, input wire i_rst_n, input wire i_scl, input wire i_sda,
  input wire o_sda, input wire o_sda_oe, input wire i_sleep_armed,
  input wire o_asleep, input wire o_ready, input wire o_stop_seen
);
  // ==========================================================
  // Recovery counted in helper logic; a delay range cannot span the real bound
  int rec_cnt = 0;
  logic asleep_q = 1'b0;
  always @(posedge i_clk_sys)
  begin
    asleep_q <= o_asleep;
    if (!i_rst_n || o_ready)
      rec_cnt <= 0;
    else if (asleep_q && !o_asleep)
      rec_cnt <= 1;
    else if (rec_cnt != 0)
      rec_cnt <= rec_cnt + 1;
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // Not ready right after wake-up
  sequence s_rec;
    !o_ready [*8];
  endsequence
  property p_rec_end; rec_cnt == REC_CYCLES |-> o_ready; endproperty
  property p_rec_low; rec_cnt != 0 && rec_cnt < REC_CYCLES |-> !o_ready; endproperty
  property p_ack; $rose(o_sda_oe) |-> i_sleep_armed && !o_asleep; endproperty
  property p_hold; $rose(o_sda_oe) |-> o_sda_oe [*6]; endproperty
  property p_rel; $fell(o_sda_oe) |-> $rose(o_asleep); endproperty
  property p_hi; $fell(o_sda_oe) |-> i_scl; endproperty
  property p_quiet; o_asleep |-> !o_sda_oe; endproperty
  property p_rdy; o_asleep |-> !o_ready; endproperty
  property p_rec; $fell(o_asleep) |-> s_rec; endproperty
  property p_stop; o_stop_seen |-> i_sda && i_scl; endproperty
  property p_od; o_sda_oe |-> !o_sda; endproperty
  a_ack: assert property (p_ack) else $error("ack when not allowed");
  a_hold: assert property (p_hold) else $error("ack too short");
  a_rel: assert property (p_rel) else $error("release without sleep");
  a_hi: assert property (p_hi) else $error("release not in clock high");
  a_quiet: assert property (p_quiet) else $error("drives data asleep");
  a_rdy: assert property (p_rdy) else $error("ready while asleep");
  a_rec: assert property (p_rec) else $error("recovery time wrong");
  a_rec_end: assert property (p_rec_end) else $error("not ready after recovery");
  a_rec_low: assert property (p_rec_low) else $error("ready before recovery ends");
  a_stop: assert property (p_stop) else $error("stop flag bad");
  a_od: assert property (p_od) else $error("data driven high");
endmodule // isl_sleep_target_sva

/* File: dv/isl_mst_bfm.sv */
// Bus master model, 80 ns bus clock
`timescale 1ns/100ps
module isl_mst_bfm
(
  // Bus pins
  input wire logic i_sda,
  output logic o_scl = 1'b1,
  output logic o_sda_oe = 1'b0
);
  // ==========================================================
  // START, eight bits MSB first, ack clock; data moves 10 ns after fall
  task frame(input logic [7:0] d, input logic hold, output logic ack);
    o_sda_oe = 1'b1;
    #40 o_scl = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      #10 o_sda_oe = !d[i];
      #30 o_scl = 1'b1;
      #40 o_scl = 1'b0;
    end
    #10 o_sda_oe = 1'b0;
    #30 o_scl = 1'b1;
    ack = !i_sda;
    o_sda_oe = hold;
    #40 o_scl = 1'b0;
  endtask
  // STOP; clock then stands high
  task stop;
    #10 o_sda_oe = 1'b1;
    #30 o_scl = 1'b1;
    #40 o_sda_oe = 1'b0;
    #40;
  endtask
endmodule // isl_mst_bfm

/* File: dv/isl_sleep_target_tb.sv */
// Testbench for the sleep-entry target
`timescale 1ns/100ps
module isl_sleep_target_tb;
  logic clk = 1'b0, rst_n = 1'b0, armed = 1'b0, ack;
  wire scl, m_oe, d_sda, d_oe, asleep, rdy, stp;
  wire sda = m_oe ? 1'b0 : (d_oe ? d_sda : 1'b1); // Pulled up, either side pulls low
  int error_cnt = 0, n_tests = 0, n_stop = 0, cyc = 0, s0;
  // Clock
  initial forever #2.5 clk = ~clk;
  isl_sleep_target #(.REC_CYCLES(50)) uut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_scl(scl),
    .i_sda(sda), .o_sda(d_sda), .o_sda_oe(d_oe), .i_sleep_armed(armed), .o_asleep(asleep),
    .o_ready(rdy), .o_stop_seen(stp));
  isl_mst_bfm mst (.i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));
  // Stop pulse count and hang limit
  always @(posedge clk)
  begin
    n_stop <= n_stop + stp;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      wrap_up;
    end
  end
  // ==========================================================
  // Compare and report
  task chk(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t got %b exp %b", $time, got, exp);
    end
  endtask
  task wrap_up;
    $display("errors %0d of %0d checks", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Byte that must not be acknowledged
  task t_refuse(input logic [7:0] d, input logic arm, input logic slp);
    armed = arm;
    mst.frame(d, 1'b0, ack);
    chk(ack, 1'b0);
    chk(asleep, slp);
    mst.stop;
  endtask
  // Final sleep byte; spurious STOP unless master holds data
  task t_sleep(input logic hold);
    armed = 1'b1;
    s0 = n_stop;
    mst.frame(8'h86, hold, ack);
    repeat (4) @(posedge clk);
    #1 chk(ack, 1'b1);
    chk(asleep, 1'b1);
    chk(rdy, 1'b0);
    chk(n_stop == s0 + !hold, 1'b1);
    armed = 1'b0;
    mst.stop;
  endtask
  // Wake address, then recovery
  task t_wake;
    mst.frame({7'h50, 1'b0}, 1'b0, ack);
    chk(ack, 1'b0);
    mst.stop;
    chk(asleep, 1'b0);
    chk(rdy, 1'b0);
    repeat (55) @(posedge clk);
    #1 chk(rdy, 1'b1);
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (5) @(posedge clk);
    #1 t_refuse(8'h86, 1'b0, 1'b0);
    t_refuse(8'h84, 1'b1, 1'b0);
    t_sleep(1'b0);
    t_refuse(8'h86, 1'b1, 1'b1);
    t_wake;
    t_sleep(1'b1);
    t_wake;
    wrap_up;
  end
endmodule // isl_sleep_target_tb
bind isl_sleep_target isl_sleep_target_sva #(.REC_CYCLES(REC_CYCLES)) u_sva (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda),
  .o_sda_oe(o_sda_oe), .i_sleep_armed(i_sleep_armed), .o_asleep(o_asleep),
  .o_ready(o_ready), .o_stop_seen(o_stop_seen));
